// file: core/gtc_regs.vh
// Register offsets, field positions, reset values and timing counts of the gated timer core.
`ifndef GTC_REGS_VH
`define GTC_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GTC_ADDR_W 3
`define GTC_OFF_CNT_LO 3'h0
`define GTC_OFF_CNT_HI 3'h1
`define GTC_OFF_CTL 3'h2
`define GTC_OFF_GATE 3'h3
`define GTC_OFF_STAT 3'h4
`define GTC_OFF_OSC 3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GTC_CTL_ON 0
`define GTC_CTL_SYNC 2
`define GTC_CTL_OSCEN 3
`define GTC_CTL_PS_LO 4
`define GTC_CTL_PS_HI 5
`define GTC_CTL_CS_LO 6
`define GTC_CTL_CS_HI 7
`define GTC_GATE_LVL 0
`define GTC_GATE_POL 6
`define GTC_GATE_GE 7
`define GTC_STAT_OVF 0
`define GTC_OSC_GO 0
`define GTC_OSC_SCS_LO 1
`define GTC_OSC_SCS_HI 2

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define GTC_CS_INSTR 2'h0
`define GTC_CS_SYS 2'h1
`define GTC_CS_EXT 2'h2
`define GTC_SCS_SECOND 2'h1

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define GTC_CNT_RST 16'h0000
`define GTC_CNT_MAX 16'hFFFF
`define GTC_CTL_RST 8'h00
`define GTC_GATE_RST 8'h00
`define GTC_OSC_RST 8'h00
`define GTC_INSTR_LAST 2'h3

`endif

// file: core/gtc_pin_sync.v
// Two-stage pin synchroniser with edge detection behind the second stage.
`timescale 1ns/1ps

module gtc_pin_sync (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Pin side
  input wire pin_i,
  // Synchronised side
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  // Two flops before any logic, then a third flop for edges.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule

// file: core/gtc_timer_core.v
// Gated 16-bit timer/counter core with prescaler, clock selection and shared oscillator request.
`timescale 1ns/1ps
`include "gtc_regs.vh"

module gtc_timer_core (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register port
  input wire [`GTC_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  // Power state
  input wire sleep_i,
  // Pins
  input wire external_count_input_i,
  input wire crystal_in_i,
  input wire gate_pin_i,
  // Oscillator sharing
  input wire [1:0] peer_osc_enable_i,
  output wire low_power_osc_enable_o,
  output wire osc_run_o,
  // Events
  output wire overflow_flag_o,
  output wire wake_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [15:0] count_q;
  reg [15:0] count_d;
  reg [2:0] presc_q;
  reg [2:0] presc_d;
  reg [7:0] ctl_q;
  reg [7:0] gate_q;
  reg [7:0] osc_q;
  reg ovf_q;
  reg wake_q;
  reg armed_q;
  reg armed_d;
  reg osc_run_q;
  reg osc_en_q;
  reg [1:0] instr_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg tick;

  wire ext_level;
  wire ext_rise;
  wire ext_fall;
  wire xtal_rise;
  wire gate_level;
  wire wr_lo;
  wire wr_hi;
  wire cnt_wr;
  wire counter_on;
  wire gate_qualify_enable;
  wire gate_polarity;
  wire sync_bypass;
  wire low_power_osc_enable;
  wire [1:0] clock_source_select;
  wire [1:0] prescale_select;
  wire [1:0] system_clock_select;
  wire low_power_osc_go;
  wire run;
  wire instr_en;
  wire advance;
  wire ovf_set;
  wire ovf_clr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Last prescale count before the counter advances.
  function [2:0] presc_last;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: presc_last = 3'h0;
        2'h1: presc_last = 3'h1;
        2'h2: presc_last = 3'h3;
        default: presc_last = 3'h7;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // pin synchroniser
  gtc_pin_sync u_ext_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(external_count_input_i),
    .level_o(ext_level),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  gtc_pin_sync u_xtal_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(crystal_in_i),
    .level_o(),
    .rise_o(xtal_rise),
    .fall_o()
  );

  gtc_pin_sync u_gate_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(gate_pin_i),
    .level_o(gate_level),
    .rise_o(),
    .fall_o()
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign counter_on = ctl_q[`GTC_CTL_ON];
  assign sync_bypass = ctl_q[`GTC_CTL_SYNC];
  assign low_power_osc_enable = ctl_q[`GTC_CTL_OSCEN];
  assign prescale_select = ctl_q[`GTC_CTL_PS_HI:`GTC_CTL_PS_LO];
  assign clock_source_select = ctl_q[`GTC_CTL_CS_HI:`GTC_CTL_CS_LO];
  assign gate_qualify_enable = gate_q[`GTC_GATE_GE];
  assign gate_polarity = gate_q[`GTC_GATE_POL];
  assign low_power_osc_go = osc_q[`GTC_OSC_GO];
  assign system_clock_select = osc_q[`GTC_OSC_SCS_HI:`GTC_OSC_SCS_LO];

  assign wr_lo = wr_i & (addr_i == `GTC_OFF_CNT_LO);
  assign wr_hi = wr_i & (addr_i == `GTC_OFF_CNT_HI);
  assign cnt_wr = wr_lo | wr_hi;

  assign run = counter_on & (~gate_qualify_enable | (gate_level == gate_polarity));

  // ----------------------------------------------------------------
  // Instruction clock divider
  // ----------------------------------------------------------------
  assign instr_en = (instr_q == `GTC_INSTR_LAST);

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      instr_q <= 2'h0;
    end else begin
      instr_q <= instr_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  // source select
  always @* begin
    tick = 1'b0;
    case (clock_source_select)
      `GTC_CS_INSTR: begin
        tick = instr_en & ~sleep_i;
      end
      `GTC_CS_SYS: begin
        tick = ~sleep_i;
      end
      `GTC_CS_EXT: begin
        if (low_power_osc_enable) begin
          tick = xtal_rise & osc_run_q;
        end else begin
          tick = ext_rise & armed_q;
        end
        tick = tick & (sync_bypass | ~sleep_i);
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    tick = tick & run;
  end

  // ----------------------------------------------------------------
  // Falling-edge arming for pin counting
  // ----------------------------------------------------------------
  // falling edge first
  always @* begin
    armed_d = armed_q;
    if (!counter_on || cnt_wr) begin
      armed_d = 1'b0;
    end else if (ext_fall) begin
      armed_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // prescale divide
  assign advance = tick & (presc_q == presc_last(prescale_select));

  always @* begin
    presc_d = presc_q;
    if (cnt_wr) begin
      presc_d = 3'h0;
    end else if (advance) begin
      presc_d = 3'h0;
    end else if (tick) begin
      presc_d = presc_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // byte writes update live count
  always @* begin
    count_d = count_q;
    if (cnt_wr) begin
      if (wr_lo) begin
        count_d[7:0] = wdata_i;
      end
      if (wr_hi) begin
        count_d[15:8] = wdata_i;
      end
    end else if (advance) begin
      count_d = count_q + 16'h0001;
    end
  end

  assign ovf_set = advance & ~cnt_wr & (count_q == `GTC_CNT_MAX);
  assign ovf_clr = wr_i & (addr_i == `GTC_OFF_STAT) & wdata_i[`GTC_STAT_OVF];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= `GTC_CNT_RST;
      presc_q <= 3'h0;
      armed_q <= 1'b0;
      ctl_q <= `GTC_CTL_RST;
      gate_q <= `GTC_GATE_RST;
      osc_q <= `GTC_OSC_RST;
      ovf_q <= 1'b0;
      wake_q <= 1'b0;
      osc_run_q <= 1'b0;
      osc_en_q <= 1'b0;
    end else begin
      count_q <= count_d;
      presc_q <= presc_d;
      armed_q <= armed_d;
      if (wr_i && (addr_i == `GTC_OFF_CTL)) begin
        ctl_q <= wdata_i;
      end
      if (wr_i && (addr_i == `GTC_OFF_GATE)) begin
        gate_q <= {wdata_i[7:6], 6'h00};
      end
      if (wr_i && (addr_i == `GTC_OFF_OSC)) begin
        osc_q <= {5'h00, wdata_i[2:0]};
      end
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
      wake_q <= ovf_set & sleep_i;
      osc_run_q <= low_power_osc_enable | (|peer_osc_enable_i) | low_power_osc_go |
                   (system_clock_select == `GTC_SCS_SECOND);
      osc_en_q <= low_power_osc_enable;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `GTC_OFF_CNT_LO: rdata_d = count_q[7:0];
        `GTC_OFF_CNT_HI: rdata_d = count_q[15:8];
        `GTC_OFF_CTL: rdata_d = ctl_q;
        `GTC_OFF_GATE: rdata_d = {gate_q[7:6], 5'h00, gate_level};
        `GTC_OFF_STAT: rdata_d = {7'h00, ovf_q};
        `GTC_OFF_OSC: rdata_d = {4'h0, osc_run_q, osc_q[2:0]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_q;
  assign overflow_flag_o = ovf_q;
  assign wake_o = wake_q;
  assign osc_run_o = osc_run_q;
  assign low_power_osc_enable_o = osc_en_q;

endmodule

// file: tb/gtc_core_props_properties.sv
// Port checker of the gated timer core.
`timescale 1ns/1ps
`include "gtc_regs.vh"
module gtc_core_props (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register port
  input wire [`GTC_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // Power state and oscillator sharing
  input wire sleep_i,
  input wire [1:0] peer_osc_enable_i,
  // Outputs
  input wire low_power_osc_enable_o,
  input wire osc_run_o,
  input wire overflow_flag_o,
  input wire wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property ($past(rd_i) && $past(addr_i) >= 3'h6 |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  flag_read_a: assert property ($past(rd_i) && $past(addr_i) == `GTC_OFF_STAT
    |-> rdata_o[0] == $past(overflow_flag_o))
    else $error("status read differs from flag");
  flag_hold_a: assert property ($past(overflow_flag_o) && !($past(wr_i) && $past(addr_i) == `GTC_OFF_STAT)
    |-> overflow_flag_o)
    else $error("overflow flag dropped");
  wake_sleep_a: assert property (wake_o |-> $past(sleep_i) && overflow_flag_o)
    else $error("wake without sleep overflow");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  osc_own_a: assert property (low_power_osc_enable_o |-> osc_run_o)
    else $error("own enable does not run oscillator");
  osc_peer_a: assert property ($past(rst_n_i) && |$past(peer_osc_enable_i) |-> osc_run_o)
    else $error("peer enable does not run oscillator");
  osc_read_a: assert property ($past(rd_i) && $past(addr_i) == `GTC_OFF_OSC
    |-> rdata_o[3] == $past(osc_run_o))
    else $error("oscillator run read differs");
  cover property ($rose(overflow_flag_o));
  cover property (wake_o);
  cover property (rd_i && addr_i == `GTC_OFF_CNT_LO);
endmodule

bind gtc_timer_core gtc_core_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
  .peer_osc_enable_i(peer_osc_enable_i), .low_power_osc_enable_o(low_power_osc_enable_o),
  .osc_run_o(osc_run_o), .overflow_flag_o(overflow_flag_o), .wake_o(wake_o));

// file: tb/gtc_pulse_src.sv
// Pulse source standing in for the count pin and the crystal.
`timescale 1ns/1ps
module gtc_pulse_src #(parameter int HALF = 4) (
  // Clock and control
  input wire clk_i,
  input wire run_i,
  // Pin side
  output logic pin_o,
  output int rises_o
);
  int cnt_q;
  initial begin
    pin_o = 1'b0;
    rises_o = 0;
    cnt_q = 0;
  end
  always @(posedge clk_i) begin
    if (run_i) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) begin
        pin_o <= !pin_o;
        rises_o <= rises_o + (pin_o ? 0 : 1);
      end
    end
  end
endmodule

// file: tb/gtc_timer_core_tb.sv
// Self-checking bench of the gated timer core.
`timescale 1ns/1ps
`include "gtc_regs.vh"
module gtc_timer_core_tb;
  logic clk_i;
  logic rst_n_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  wire [7:0] rdata_o;
  logic sleep_i;
  wire ext_pin;
  wire xtl_pin;
  logic gate_pin;
  logic [1:0] peer;
  logic src_run;
  wire en_o;
  wire run_o;
  wire flag_o;
  wire wake_o;
  int ext_r;
  int xtl_r;
  int r0;
  int x0;
  int n_errors;
  int comparisons;
  int n_wake;
  int cyc;
  int seed;
  int i;
  logic [7:0] d;
  logic [7:0] r;
  logic [15:0] v;
  gtc_pulse_src #(.HALF(4)) ext_src (.clk_i(clk_i), .run_i(src_run), .pin_o(ext_pin), .rises_o(ext_r));
  gtc_pulse_src #(.HALF(8)) xtl_src (.clk_i(clk_i), .run_i(src_run), .pin_o(xtl_pin), .rises_o(xtl_r));
  gtc_timer_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .external_count_input_i(ext_pin),
    .crystal_in_i(xtl_pin), .gate_pin_i(gate_pin), .peer_osc_enable_i(peer),
    .low_power_osc_enable_o(en_o), .osc_run_o(run_o), .overflow_flag_o(flag_o), .wake_o(wake_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("errors %0d of %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wake_o === 1'b1) begin
      n_wake <= n_wake + 1;
    end
    if (cyc > 30000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic near(input string n, input logic [15:0] e, input logic [15:0] g, input int t);
    comparisons++;
    if (^g === 1'bx || int'(g) > int'(e) + t || int'(g) + t < int'(e)) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    near(n, e, g, 0);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  function automatic logic [15:0] ticks(input logic [7:0] c, input int n);
    int t;
    t = (c[7:6] == `GTC_CS_SYS) ? n : n / 4;
    return 16'(t >> c[5:4]);
  endfunction
  task automatic run(input logic [7:0] c, input logic [15:0] s, input int n, output logic [15:0] q);
    logic [7:0] lo;
    logic [7:0] hi;
    wr(`GTC_OFF_CNT_LO, s[7:0]);
    wr(`GTC_OFF_CNT_HI, s[15:8]);
    r0 = ext_r;
    x0 = xtl_r;
    wr(`GTC_OFF_CTL, c);
    if (n > 0) begin
      src_run <= 1'b1;
      repeat (n) @(posedge clk_i);
      src_run <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    wr(`GTC_OFF_CTL, c & 8'hfe);
    rd(`GTC_OFF_CNT_LO, lo);
    rd(`GTC_OFF_CNT_HI, hi);
    q = {hi, lo};
  endtask
  initial begin
    seed = 96;
    rst_n_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sleep_i = 1'b0;
    gate_pin = 1'b0;
    peer = 2'b00;
    src_run = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(i[2:0], r & 8'hfe);
      rd(i[2:0], d);
      chk("readback", {8'h00, (i == 3) ? (r & 8'hc0) : (r & 8'hfe)}, {8'h00, d});
    end
    wr(`GTC_OFF_CTL, 8'h00);
    wr(`GTC_OFF_GATE, 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      r = {1'b0, i[0], i[2:1], 4'h1};
      run(r, 16'h0000, 64, v);
      near("timer count", ticks(r, 72), v, 2);
    end
    for (i = 0; i < 4; i++) begin
      gate_pin <= i[0];
      wr(`GTC_OFF_GATE, {1'b1, i[1], 6'h00});
      run(8'h41, 16'h0000, 64, v);
      near("gated count", (i[0] == i[1]) ? 16'h0048 : 16'h0000, v, 2);
    end
    wr(`GTC_OFF_GATE, 8'h00);
    run(8'h40, 16'h0000, 64, v);
    chk("off count", 16'h0000, v);
    $display("test timer done");
    run(8'h81, 16'h0100, 64, v);
    chk("pin count", 16'(16'h0100 + ext_r - r0 - 1), v);
    wr(`GTC_OFF_CTL, 8'h88);
    repeat (8) @(posedge clk_i);
    chk("osc enable out", 16'h0001, {15'h0000, en_o});
    run(8'h89, 16'h0000, 64, v);
    near("crystal count", 16'(xtl_r - x0), v, 1);
    wr(`GTC_OFF_CTL, 8'h70);
    wr(`GTC_OFF_CTL, 8'h71);
    for (i = 0; i < 10; i++) begin
      wr(i[0] ? `GTC_OFF_CNT_HI : `GTC_OFF_CNT_LO, 8'h00);
      repeat (4) @(posedge clk_i);
    end
    run(8'h70, 16'h0000, 0, v);
    chk("prescale cleared", 16'h0000, v);
    $display("test pin done");
    run(8'h41, 16'hfff0, 64, v);
    chk("overflow flag", 16'h0001, {15'h0000, flag_o});
    near("wrapped count", 16'h0038, v, 2);
    wr(`GTC_OFF_STAT, 8'h01);
    #1 chk("flag cleared", 16'h0000, {15'h0000, flag_o});
    sleep_i <= 1'b1;
    n_wake = 0;
    run(8'h85, 16'hfffe, 64, v);
    chk("sleep count", 16'(16'hfffe + ext_r - r0 - 1), v);
    chk("wake pulses", 16'h0001, 16'(n_wake));
    run(8'h41, 16'h0000, 64, v);
    chk("sleep halt", 16'h0000, v);
    sleep_i <= 1'b0;
    wr(`GTC_OFF_STAT, 8'h01);
    $display("test sleep done");
    for (i = 0; i < 4; i++) begin
      peer <= (i == 0) ? 2'b10 : 2'b00;
      wr(`GTC_OFF_OSC, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
      repeat (2) @(posedge clk_i);
      rd(`GTC_OFF_OSC, d);
      chk("osc run", {15'h0000, i != 3}, {15'h0000, d[3]});
      chk("osc run out", {15'h0000, i != 3}, {15'h0000, run_o});
    end
    chk("osc enable off", 16'h0000, {15'h0000, en_o});
    $display("test oscillator done");
    finish_test();
  end
endmodule
